/* File: verilog/mrd_defs.vh */
// constants for the read data recovery block
//
// Operation
// RULE1 - while power_on_init_n is low, clock calibration counter at 460 kHz
// RULE2 - count up while comparator shows bias below threshold; count drives DAC
// RULE3 - on comparator flip take one step down, then resume counting up
// RULE4 - when power_on_init_n rises stop counting and hold the threshold value
// RULE5 - drop pulses within a quarter cell of the centre of an IF pattern
// RULE6 - either polarity of flux transition yields exactly one pulse
// RULE7 - normal window set at T2 and reset at T6 of PLL cell phases
// RULE8 - sample window with strobe delayed half a cell, centred on 2F pattern
// RULE9 - sample gives ones as pulses; next stage forms NRZ plus read clock
// RULE10 - select code weights 4,2,1 from inverted margin, late, early inputs
// RULE11 - codes one to seven pick the tabled set and reset phases
// RULE12 - early/late shift both boundaries; margin pulls both inward (codes 6 and 7 keep full width, set T1/reset T5 and set T3/reset T7)
// RULE13 - circulating one in eight-stage ring splits each cell in eight
// RULE14 - both oscillator phases give sixteen sub-cell intervals
// RULE15 - calibration counter saturates at both ends
// RULE16 - window select changes only take effect at a cell boundary
`ifndef MRD_DEFS_VH
`define MRD_DEFS_VH

// ==========================================================
// clocks
`define MRD_CLK_HZ       40000000
`define MRD_CAL_HZ       460000
`define MRD_CAL_DIV      (`MRD_CLK_HZ / `MRD_CAL_HZ)
// last divider count, integer divide gives 86 clocks per tick
`define MRD_CAL_LAST     7'h55

// ==========================================================
// cell phase positions, code = 2 * T + split half
`define MRD_POS_T1       4'h2
`define MRD_POS_T1H      4'h3
`define MRD_POS_T2       4'h4
`define MRD_POS_T2H      4'h5
`define MRD_POS_T3       4'h6
`define MRD_POS_T5       4'hA
`define MRD_POS_T5H      4'hB
`define MRD_POS_T6       4'hC
`define MRD_POS_T6H      4'hD
`define MRD_POS_T7       4'hE
`define MRD_POS_CLK_END  4'h8

// ==========================================================
// sub-interval timing, sixteen per cell
`define MRD_SUB_PER_CELL 6'h10
`define MRD_STROBE_DLY   4'h8
`define MRD_IF_MIN_SUB   6'h1C
`define MRD_REJ_LO       6'h0C
`define MRD_REJ_HI       6'h14
`define MRD_ELAPSED_MAX  6'h3F

// ==========================================================
// reset values
`define MRD_RING_RST     8'h01
`define MRD_SEL_RST      3'h0
`define MRD_CAL_RST      6'h00
// mode pins idle high, others idle low
`define MRD_PIN_RST      6'h38

`endif

/* File: verilog/mrd_fifo.v */
// small synchronous fifo with registered read data
`timescale 1ns/10ps
`default_nettype none

module mrd_fifo #(
    parameter WIDTH = 1,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    input  wire             clk_sys,
    input  wire             rst_b,
    input  wire [WIDTH-1:0] in_data,
    input  wire             in_valid,
    output wire             in_ready,
    output reg  [WIDTH-1:0] out_data,
    output reg              out_valid,
    input  wire             out_ready
);

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr;
    reg [AW-1:0]    rd_ptr;
    reg [AW:0]      count;
    wire            push;
    wire            pop;

    assign in_ready = (count != DEPTH[AW:0]);
    assign push     = in_valid && in_ready;
    // pull into the output register when it is empty or being taken
    assign pop      = (count != {(AW+1){1'b0}}) && (!out_valid || out_ready);

    always @(posedge clk_sys) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            wr_ptr    <= {AW{1'b0}};
            rd_ptr    <= {AW{1'b0}};
            count     <= {(AW+1){1'b0}};
            out_data  <= {WIDTH{1'b0}};
            out_valid <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr   <= rd_ptr + 1'b1;
                out_data <= mem[rd_ptr];
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
            if (pop) begin
                out_valid <= 1'b1;
            end else if (out_ready) begin
                out_valid <= 1'b0;
            end
        end
    end

endmodule

`default_nettype wire

/* File: verilog/mrd_read_recovery.v */
// read channel: threshold calibration, pulse cleanup, window and nrz recovery
`timescale 1ns/10ps
`default_nettype none
`include "mrd_defs.vh"

module mrd_read_recovery #(
    parameter CAL_W      = 6,
    parameter FIFO_DEPTH = 16,
    parameter FIFO_AW    = 4
) (
    input  wire             clk_sys,
    input  wire             rst_b,
    input  wire             power_on_init_n,
    input  wire             comparator_below,
    output reg  [CAL_W-1:0] threshold_code,
    input  wire             read_pulse_positive,
    input  wire             read_pulse_negative,
    input  wire             sub_tick,
    input  wire             window_shift_advance_n,
    input  wire             window_shift_delay_n,
    input  wire             margin_mode_n,
    output reg  [2:0]       window_select,
    output reg              half_cell_sample_strobe,
    output reg              recovered_read_clock,
    output reg              false_pulse_drop,
    output reg              fifo_overrun,
    output wire             nrz_data,
    output wire             nrz_valid,
    input  wire             nrz_ready
);

    // ==========================================================
    // pin synchronisers, three stages, settle when 2 and 3 agree
    localparam NPIN = 6;

    wire [NPIN-1:0] pin_raw;
    reg  [NPIN-1:0] pin_s1;
    reg  [NPIN-1:0] pin_s2;
    reg  [NPIN-1:0] pin_s3;
    reg  [NPIN-1:0] pin_f;
    reg  [NPIN-1:0] pin_f_d;

    assign pin_raw = {margin_mode_n, window_shift_delay_n, window_shift_advance_n,
                      comparator_below, read_pulse_negative, read_pulse_positive};

    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            pin_s1  <= `MRD_PIN_RST;
            pin_s2  <= `MRD_PIN_RST;
            pin_s3  <= `MRD_PIN_RST;
            pin_f   <= `MRD_PIN_RST;
            pin_f_d <= `MRD_PIN_RST;
        end else begin
            pin_s1  <= pin_raw;
            pin_s2  <= pin_s1;
            pin_s3  <= pin_s2;
            pin_f   <= (pin_s2 & pin_s3) | (pin_f & (pin_s2 ^ pin_s3));
            pin_f_d <= pin_f;
        end
    end

    // power_on_init_n passes the same chain separately
    reg init_s1;
    reg init_s2;
    reg init_s3;
    reg init_f;

    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            init_s1 <= 1'b0;
            init_s2 <= 1'b0;
            init_s3 <= 1'b0;
            init_f  <= 1'b0;
        end else begin
            init_s1 <= power_on_init_n;
            init_s2 <= init_s1;
            init_s3 <= init_s2;
            if (init_s2 == init_s3) begin
                init_f <= init_s3;
            end
        end
    end

    wire below  = pin_f[2];
    wire pos_up = pin_f[0] && !pin_f_d[0];
    wire neg_up = pin_f[1] && !pin_f_d[1];

    // ==========================================================
    // threshold calibration
    reg [6:0] cal_div;
    reg       cal_tick;
    reg       cal_stepped;

    // RULE1 low-rate calibration clock
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            cal_div  <= 7'h00;
            cal_tick <= 1'b0;
        end else if (!init_f) begin
            if (cal_div == `MRD_CAL_LAST) begin
                cal_div  <= 7'h00;
                cal_tick <= 1'b1;
            end else begin
                cal_div  <= cal_div + 7'h01;
                cal_tick <= 1'b0;
            end
        end else begin
            // RULE4 clock stops, value held
            cal_div  <= 7'h00;
            cal_tick <= 1'b0;
        end
    end

    wire cal_max = (threshold_code == {CAL_W{1'b1}});
    wire cal_min = (threshold_code == {CAL_W{1'b0}});

    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            threshold_code <= {CAL_W{1'b0}};
            cal_stepped    <= 1'b0;
        end else if (cal_tick && !init_f) begin
            if (below || cal_stepped) begin
                // RULE2 count up toward threshold
                // RULE15 hold at the top
                if (!cal_max) begin
                    threshold_code <= threshold_code + 1'b1;
                end
                cal_stepped <= 1'b0;
            end else begin
                // RULE3 single step down on flip
                // RULE15 hold at the bottom
                if (!cal_min) begin
                    threshold_code <= threshold_code - 1'b1;
                end
                cal_stepped <= 1'b1;
            end
        end
    end

    // ==========================================================
    // cell phase ring and split half
    reg  [7:0] ring;
    reg        half;
    reg  [2:0] ring_idx;
    integer    k;

    // RULE13 circulating one, eight intervals
    // RULE14 split half gives sixteen
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ring <= `MRD_RING_RST;
            half <= 1'b0;
        end else if (sub_tick) begin
            half <= !half;
            if (half) begin
                ring <= {ring[6:0], ring[7]};
            end
        end
    end

    always @* begin
        ring_idx = 3'h0;
        for (k = 0; k < 8; k = k + 1) begin
            if (ring[k]) begin
                ring_idx = k[2:0];
            end
        end
    end

    wire [3:0] pos        = {ring_idx, half};
    wire       cell_bound = sub_tick && half && ring[7];

    // ==========================================================
    // window select code and phase table
    reg  [3:0] win_set_pos;
    reg  [3:0] win_rst_pos;
    wire [2:0] next_select = {~pin_f[5], ~pin_f[4], ~pin_f[3]};

    // RULE10 select code weights 4,2,1
    // RULE16 update only at a cell boundary
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            window_select <= `MRD_SEL_RST;
        end else if (cell_bound) begin
            window_select <= next_select;
        end
    end

    // RULE11 set and reset phase per code
    // RULE12 shift early, late or inward
    always @* begin
        case (window_select)
            3'h1: begin
                win_set_pos = `MRD_POS_T1H;
                win_rst_pos = `MRD_POS_T5H;
            end
            3'h2: begin
                win_set_pos = `MRD_POS_T2H;
                win_rst_pos = `MRD_POS_T6H;
            end
            3'h4: begin
                win_set_pos = `MRD_POS_T2H;
                win_rst_pos = `MRD_POS_T5H;
            end
            3'h5: begin
                win_set_pos = `MRD_POS_T3;
                win_rst_pos = `MRD_POS_T5;
            end
            3'h6: begin
                win_set_pos = `MRD_POS_T1;
                win_rst_pos = `MRD_POS_T5;
            end
            3'h7: begin
                win_set_pos = `MRD_POS_T3;
                win_rst_pos = `MRD_POS_T7;
            end
            default: begin
                // RULE7 normal window T2 to T6
                win_set_pos = `MRD_POS_T2;
                win_rst_pos = `MRD_POS_T6;
            end
        endcase
    end

    reg window_ff;

    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            window_ff <= 1'b0;
        end else if (pos == win_set_pos) begin
            window_ff <= 1'b1;
        end else if (pos == win_rst_pos) begin
            window_ff <= 1'b0;
        end
    end

    // ==========================================================
    // flux pulses and false zero-crossing rejection
    reg  [5:0] elapsed;
    reg        if_pattern;
    wire       flux_evt;
    wire       in_centre;
    wire       accept;

    // RULE6 either polarity gives one event
    assign flux_evt  = pos_up || neg_up;
    assign in_centre = (elapsed >= `MRD_REJ_LO) && (elapsed <= `MRD_REJ_HI);
    // RULE5 drop pulses near the IF centre
    assign accept    = flux_evt && !(if_pattern && in_centre);

    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            elapsed          <= `MRD_ELAPSED_MAX;
            if_pattern       <= 1'b0;
            false_pulse_drop <= 1'b0;
        end else begin
            false_pulse_drop <= flux_evt && !accept;
            if (accept) begin
                if_pattern <= (elapsed >= `MRD_IF_MIN_SUB);
                elapsed    <= sub_tick ? 6'h01 : 6'h00;
            end else if (sub_tick && elapsed != `MRD_ELAPSED_MAX) begin
                elapsed <= elapsed + 6'h01;
            end
        end
    end

    // ==========================================================
    // half-cell delayed sample strobe
    reg [3:0] strobe_cnt;
    reg       strobe_arm;

    // RULE8 strobe half a cell after the pulse
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            strobe_cnt              <= 4'h0;
            strobe_arm              <= 1'b0;
            half_cell_sample_strobe <= 1'b0;
        end else begin
            half_cell_sample_strobe <= 1'b0;
            if (accept) begin
                strobe_cnt <= `MRD_STROBE_DLY;
                strobe_arm <= 1'b1;
            end else if (strobe_arm && sub_tick) begin
                if (strobe_cnt == 4'h1) begin
                    strobe_arm              <= 1'b0;
                    half_cell_sample_strobe <= 1'b1;
                end
                strobe_cnt <= strobe_cnt - 4'h1;
            end
        end
    end

    // ==========================================================
    // nrz forming and read clock
    reg one_seen;
    reg nrz_bit;
    reg nrz_push;

    // RULE8 sample the window
    // RULE9 ones arrive as pulses, zeros as level
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            one_seen <= 1'b0;
            nrz_bit  <= 1'b0;
            nrz_push <= 1'b0;
        end else begin
            nrz_push <= cell_bound;
            if (cell_bound) begin
                nrz_bit <= one_seen || (half_cell_sample_strobe && window_ff);
            end
            // a sample on the boundary cycle is kept, not lost
            if (half_cell_sample_strobe && window_ff) begin
                one_seen <= 1'b1;
            end else if (cell_bound) begin
                one_seen <= 1'b0;
            end
        end
    end

    // RULE9 read clock high in the first half cell
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            recovered_read_clock <= 1'b0;
        end else begin
            recovered_read_clock <= (pos < `MRD_POS_CLK_END);
        end
    end

    // ==========================================================
    // output fifo
    wire fifo_in_ready;

    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            fifo_overrun <= 1'b0;
        end else if (nrz_push && !fifo_in_ready) begin
            fifo_overrun <= 1'b1;
        end else if (!init_f) begin
            fifo_overrun <= 1'b0;
        end
    end

    mrd_fifo #(
        .WIDTH (1),
        .DEPTH (FIFO_DEPTH),
        .AW    (FIFO_AW)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .rst_b     (rst_b),
        .in_data   (nrz_bit),
        .in_valid  (nrz_push),
        .in_ready  (fifo_in_ready),
        .out_data  (nrz_data),
        .out_valid (nrz_valid),
        .out_ready (nrz_ready)
    );

endmodule

`default_nettype wire

/* File: testbench/mrd_read_recovery_chk.sv */
// assertions on the read data recovery block ports
`timescale 1ns/10ps
`default_nettype none
module mrd_read_recovery_chk #(
    parameter CAL_W = 6
) (
    input wire logic             clk_sys,
    input wire logic             rst_b,
    input wire logic             power_on_init_n,
    input wire logic [CAL_W-1:0] threshold_code,
    input wire logic             sub_tick,
    input wire logic             window_shift_advance_n,
    input wire logic             window_shift_delay_n,
    input wire logic             margin_mode_n,
    input wire logic [2:0]       window_select,
    input wire logic             half_cell_sample_strobe,
    input wire logic             recovered_read_clock,
    input wire logic             nrz_data,
    input wire logic             nrz_valid,
    input wire logic             nrz_ready
);
    logic       rc_q;
    logic       armed;
    logic [4:0] nt;
    // ==========================================
    // sub_ticks seen per read clock phase
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rc_q  <= 1'b0;
            armed <= 1'b0;
            nt    <= 5'h00;
        end else begin
            rc_q <= recovered_read_clock;
            if (recovered_read_clock != rc_q) begin
                armed <= 1'b1;
                nt    <= {4'h0, sub_tick};
            end else begin
                nt <= nt + {4'h0, sub_tick};
            end
        end
    end
    // ==========================================
    // properties
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);
    property p_cal_step;
        $changed(threshold_code) |->
            (threshold_code - $past(threshold_code)) inside {CAL_W'(1), {CAL_W{1'b1}}};
    endproperty
    a_cal_step: assert property (p_cal_step)
        else $error("threshold moved by more than one");
    property p_cal_sat;
        $changed(threshold_code) |-> (threshold_code > $past(threshold_code))
            == (threshold_code == $past(threshold_code) + CAL_W'(1));
    endproperty
    a_cal_sat: assert property (p_cal_sat)
        else $error("threshold wrapped");
    property p_cal_gap;
        $changed(threshold_code) |=> $stable(threshold_code)[*8];
    endproperty
    a_cal_gap: assert property (p_cal_gap)
        else $error("threshold steps too close");
    property p_cal_hold;
        power_on_init_n[*8] |=> $stable(threshold_code);
    endproperty
    a_cal_hold: assert property (p_cal_hold)
        else $error("threshold moved after init");
    property p_sel_bound;
        $changed(window_select) |-> $past(sub_tick) && !recovered_read_clock;
    endproperty
    a_sel_bound: assert property (p_sel_bound)
        else $error("select changed inside a cell");
    property p_sel_val;
        $changed(window_select) |->
            window_select == ~{margin_mode_n, window_shift_delay_n, window_shift_advance_n};
    endproperty
    a_sel_val: assert property (p_sel_val)
        else $error("select code wrong");
    property p_rclk_len;
        armed && (recovered_read_clock != rc_q) |-> nt == 5'h08;
    endproperty
    a_rclk_len: assert property (p_rclk_len)
        else $error("read clock phase not eight sub_ticks");
    property p_strobe;
        half_cell_sample_strobe |-> $past(sub_tick) ##1 !half_cell_sample_strobe;
    endproperty
    a_strobe: assert property (p_strobe)
        else $error("strobe not one cycle after sub_tick");
    property p_nrz_hold;
        nrz_valid && !nrz_ready |=> nrz_valid && $stable(nrz_data);
    endproperty
    a_nrz_hold: assert property (p_nrz_hold)
        else $error("nrz bit not held");
endmodule
`default_nettype wire

/* File: testbench/mrd_nrz_sink.sv */
// model of the interface board taking recovered nrz bits
`timescale 1ns/10ps
`default_nettype none
module mrd_nrz_sink (
    input  wire logic clk_sys,
    input  wire logic rst_b,
    input  wire logic stall,
    input  wire logic nrz_data,
    input  wire logic nrz_valid,
    output var  logic nrz_ready
);
    int   ones;
    int   bits;
    logic slow;
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ones      <= 0;
            bits      <= 0;
            slow      <= 1'b0;
            nrz_ready <= 1'b0;
        end else begin
            slow      <= ~slow;
            nrz_ready <= !stall && slow;
            if (nrz_valid && nrz_ready) begin
                bits <= bits + 1;
                ones <= ones + (nrz_data ? 1 : 0);
            end
        end
    end
endmodule
`default_nettype wire

/* File: testbench/tb_mrd_read_recovery.sv */
// self-checking bench for the read data recovery block
`timescale 1ns/10ps
`default_nettype none
module tb_mrd_read_recovery;
    localparam logic [3:0] ws [8] = '{4'h4, 4'h3, 4'h5, 4'h4, 4'h5, 4'h6, 4'h2, 4'h6};
    localparam logic [3:0] wr [8] = '{4'hC, 4'hB, 4'hD, 4'hC, 4'hB, 4'hA, 4'hA, 4'hE};
    localparam logic [3:0] wm [8] = '{4'h8, 4'h7, 4'h9, 4'h8, 4'h8, 4'h8, 4'h6, 4'hA};
    logic       clk_sys  = 1'b0;
    logic       rst_b    = 1'b0;
    logic       init_n   = 1'b0;
    logic       cmp_bel  = 1'b0;
    logic       rp_pos   = 1'b0;
    logic       rp_neg   = 1'b0;
    logic       sub_tick = 1'b0;
    logic       tick_en  = 1'b0;
    logic       stall    = 1'b0;
    logic [2:0] mode_n   = 3'h7;
    logic [2:0] tdiv     = 3'h0;
    logic [3:0] tpos     = 4'h0;
    logic [6:0] target   = 7'h00;
    logic [5:0] thr;
    logic [2:0] wsel;
    logic       drop;
    logic       strb;
    logic       rclk;
    logic       ovr;
    logic       nrz_d;
    logic       nrz_v;
    logic       nrz_r;
    int         err_count   = 0;
    int         comparisons = 0;
    int         drops       = 0;
    int         strobes     = 0;
    int         snap;
    int         snap_s;

    always #12.5 clk_sys = ~clk_sys;

    mrd_read_recovery dut (
        .clk_sys                 (clk_sys),
        .rst_b                   (rst_b),
        .power_on_init_n         (init_n),
        .comparator_below        (cmp_bel),
        .threshold_code          (thr),
        .read_pulse_positive     (rp_pos),
        .read_pulse_negative     (rp_neg),
        .sub_tick                (sub_tick),
        .window_shift_advance_n  (mode_n[0]),
        .window_shift_delay_n    (mode_n[1]),
        .margin_mode_n           (mode_n[2]),
        .window_select           (wsel),
        .half_cell_sample_strobe (strb),
        .recovered_read_clock    (rclk),
        .false_pulse_drop        (drop),
        .fifo_overrun            (ovr),
        .nrz_data                (nrz_d),
        .nrz_valid               (nrz_v),
        .nrz_ready               (nrz_r)
    );

    mrd_nrz_sink sink (
        .clk_sys   (clk_sys),
        .rst_b     (rst_b),
        .stall     (stall),
        .nrz_data  (nrz_d),
        .nrz_valid (nrz_v),
        .nrz_ready (nrz_r)
    );

    // ==========================================
    // comparator model, sub_tick source, monitors
    always @(posedge clk_sys) begin
        cmp_bel  <= {1'b0, thr} < target;
        tdiv     <= tick_en ? tdiv + 3'h1 : 3'h0;
        sub_tick <= tick_en && tdiv == 3'h0;
        if (sub_tick === 1'b1) tpos <= tpos + 4'h1;
        if (drop === 1'b1) drops <= drops + 1;
        if (strb === 1'b1) strobes <= strobes + 1;
    end

    // ==========================================
    // tasks
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wt(input int n);
        repeat (n) begin
            @(posedge clk_sys);
            while (sub_tick !== 1'b1) @(posedge clk_sys);
        end
        #2;
    endtask

    task automatic pulse(input logic pol);
        if (pol) rp_pos = 1'b1;
        else rp_neg = 1'b1;
        repeat (2) @(posedge clk_sys);
        #2;
        rp_pos = 1'b0;
        rp_neg = 1'b0;
    endtask

    // one flux pulse timed so its strobe lands at half-interval q
    task automatic trial(input logic [3:0] q, input logic ex, input logic pol);
        wt(1);
        while (tpos !== q - 4'h8) wt(1);
        snap = sink.ones;
        snap_s = strobes;
        pulse(pol);
        wt(48);
        check(8'(sink.ones - snap), {7'h00, ex});
        check(8'(strobes - snap_s), 8'h01);
    endtask

    task automatic print_verdict();
        $display("comparisons %0d err_count %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ==========================================
    // main sequence
    initial begin
        repeat (3) @(posedge clk_sys);
        #2;
        rst_b = 1'b1;
        repeat (5) @(posedge clk_sys);
        #2;
        tick_en = 1'b1;
        repeat (300) @(posedge clk_sys);
        check(8'(thr <= 6'h01), 8'h01);
        target = 7'h14;
        repeat (3000) @(posedge clk_sys);
        check(8'(thr inside {6'h13, 6'h14}), 8'h01);
        target = 7'h40;
        repeat (4500) @(posedge clk_sys);
        check({2'b00, thr}, 8'h3F);
        init_n = 1'b1;
        repeat (10) @(posedge clk_sys);
        target = 7'h00;
        repeat (400) @(posedge clk_sys);
        check({2'b00, thr}, 8'h3F);
        for (int c = 0; c < 8; c++) begin
            wt(1);
            mode_n = ~3'(c);
            wt(40);
            check({5'h00, wsel}, 8'(c));
            trial(wm[c], 1'b1, c[0]);
            trial(ws[c] - 4'h2, 1'b0, !c[0]);
            trial(wr[c] + 4'h1, 1'b0, c[1]);
        end
        snap = drops;
        pulse(1'b1);
        wt(32);
        pulse(1'b0);
        wt(16);
        pulse(1'b1);
        wt(16);
        pulse(1'b0);
        wt(8);
        pulse(1'b1);
        wt(16);
        pulse(1'b0);
        wt(4);
        check(8'(drops - snap), 8'h01);
        stall = 1'b1;
        wt(320);
        check({6'h00, nrz_v, ovr}, 8'h03);
        snap = sink.bits;
        stall = 1'b0;
        wt(16);
        check(8'(sink.bits - snap >= 16), 8'h01);
        while (tpos !== 4'h4) wt(1);
        check({7'h00, rclk}, 8'h01);
        while (tpos !== 4'hC) wt(1);
        check({7'h00, rclk}, 8'h00);
        while (tpos !== 4'h8) wt(1);
        check({7'h00, nrz_v}, 8'h00);
        check({7'h00, ovr}, 8'h01);
        init_n = 1'b0;
        repeat (10) @(posedge clk_sys);
        check({7'h00, ovr}, 8'h00);
        print_verdict();
    end

    initial begin
        repeat (50000) @(posedge clk_sys);
        err_count++;
        print_verdict();
    end
endmodule

bind mrd_read_recovery mrd_read_recovery_chk #(.CAL_W(CAL_W)) chk (
    .clk_sys                 (clk_sys),
    .rst_b                   (rst_b),
    .power_on_init_n         (power_on_init_n),
    .threshold_code          (threshold_code),
    .sub_tick                (sub_tick),
    .window_shift_advance_n  (window_shift_advance_n),
    .window_shift_delay_n    (window_shift_delay_n),
    .margin_mode_n           (margin_mode_n),
    .window_select           (window_select),
    .half_cell_sample_strobe (half_cell_sample_strobe),
    .recovered_read_clock    (recovered_read_clock),
    .nrz_data                (nrz_data),
    .nrz_valid               (nrz_valid),
    .nrz_ready               (nrz_ready)
);
`default_nettype wire
